// ===== rtl/hvb_bridge.sv
// Processor-side command and data registers of the high-voltage bridge.
`timescale 1ns/1ps
// What this block does
// - Codes 0x00-0x03 fetch first config, second config, status, monitor.
// - Codes 0x08 and 0x09 write data low byte to first/second config.
// - Commands travel over a data line and a 2.56 MHz clock line.
// - A command reaches the indirect registers within 10 us.
// - Read results land in the data register about 10 us later.
// - Command register bit 0 reads 1 while a command is in progress.
// - Status bits 1 and 2 are valid only once busy is 0.
// - Bit 2 reads 1 when the last transmission to the die succeeded.
// - Bit 1 reads 1 when the last read from the die succeeded.
// - Data register is 12 bits; upper bits read-only command code.
// - Data low byte holds the byte written or the byte read back.
// - Indirect registers are reachable only through these two registers.
// - Command register is 8 bits; only the six codes above decode as commands, other bytes are ignored.
// - Configuration registers are 8 bits and reset to zero.
module hvb_bridge #(
	parameter int SCLK_DIV = hvb_pkg::HVB_SCLK_DIV
) (
	input  wire logic        clk_in,              // Bus clock, 40 MHz
	input  wire logic        sys_rst_in,          // Synchronous reset
	input  wire logic [31:0] mmr_addr_in,         // Register byte address
	input  wire logic        mmr_wr_in,           // Write strobe
	input  wire logic        mmr_rd_in,           // Read strobe
	input  wire logic [31:0] mmr_wdata_in,        // Write data
	output logic      [31:0] mmr_rdata_out,       // Read data, registered
	output logic             busy_out,            // Command in progress
	output logic [hvb_pkg::HVB_BYTE_W-1:0] hv_config_first_out,  // Mirror
	output logic [hvb_pkg::HVB_BYTE_W-1:0] hv_config_second_out, // Mirror
	input  wire logic        hv_clk_in,           // Link clock
	output logic             hv_sclk_out,         // Serial clock to die
	input  wire logic        hv_sdata_in,         // Serial data from die
	output logic             hv_sdata_out,        // Serial data to die
	output logic             hv_sdata_oe_n_out    // Low while driving
);
	import hvb_pkg::*;

	typedef struct packed {
		logic        busy;
		logic        tx_ok;
		logic        rd_ok;
		logic [3:0]  code;
		logic [7:0]  data;
		logic [7:0]  pend_cmd;
		logic        req_tgl;
		logic        ack_m;
		logic        ack_s;
		logic        ack_seen;
		logic [7:0]  cfg_first;
		logic [7:0]  cfg_second;
		logic [31:0] rdata;
	} hvb_bus_s;

	hvb_bus_s    st_r;
	hvb_bus_s    st_nxt;
	hvb_xfer_if  xfer ();

	logic        hit_cmd;
	logic        hit_dat;
	logic        cmd_valid;
	logic        cmd_is_wr;
	logic        ack_evt;
	logic [7:0]  wr_byte;

	// ----------------------------------------------------------------
	// Address and command decode
	// ----------------------------------------------------------------
	assign hit_cmd = (mmr_addr_in == HVB_CMD_ADDR);
	assign hit_dat = (mmr_addr_in == HVB_DAT_ADDR);
	assign wr_byte = mmr_wdata_in[HVB_CMD_W-1:0];

	always_comb begin
		case (wr_byte)
			HVB_RD_CFG_FIRST,
			HVB_RD_CFG_SECOND,
			HVB_RD_STATUS,
			HVB_RD_MONITOR: cmd_valid = 1'b1;
			HVB_WR_CFG_FIRST,
			HVB_WR_CFG_SECOND: cmd_valid = 1'b1;
			default: cmd_valid = 1'b0;
		endcase
	end

	assign cmd_is_wr = st_r.pend_cmd[HVB_WR_CMD_BIT];
	assign ack_evt   = (st_r.ack_s != st_r.ack_seen);

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt       = st_r;
		st_nxt.ack_m = xfer.ack_tgl;
		st_nxt.ack_s = st_r.ack_m;

		// A finished frame hands back its result and releases busy.
		if (ack_evt) begin
			st_nxt.ack_seen = st_r.ack_s;
			st_nxt.busy     = 1'b0;
			st_nxt.code     = st_r.pend_cmd[HVB_CODE_W-1:0];
			if (cmd_is_wr) begin
				st_nxt.tx_ok = xfer.ok;
				if (xfer.ok) begin
					if (st_r.pend_cmd == HVB_WR_CFG_FIRST)
						st_nxt.cfg_first = st_r.data;
					else
						st_nxt.cfg_second = st_r.data;
				end
			end else begin
				st_nxt.tx_ok = 1'b1;
				st_nxt.rd_ok = xfer.ok;
				if (xfer.ok) begin
					st_nxt.data = xfer.rdata;
					if (st_r.pend_cmd == HVB_RD_CFG_FIRST)
						st_nxt.cfg_first = xfer.rdata;
					if (st_r.pend_cmd == HVB_RD_CFG_SECOND)
						st_nxt.cfg_second = xfer.rdata;
				end
			end
		end

		// Writes are ignored while busy so the crossing data stays stable.
		if (mmr_wr_in && !st_r.busy) begin
			if (hit_cmd && cmd_valid) begin
				st_nxt.pend_cmd = wr_byte;
				st_nxt.busy     = 1'b1;
				st_nxt.req_tgl  = ~st_r.req_tgl;
			end
			if (hit_dat)
				st_nxt.data = mmr_wdata_in[HVB_BYTE_W-1:0];
		end

		// Reads answer one cycle after the strobe; unmapped reads give 0.
		st_nxt.rdata = 32'h0000_0000;
		if (mmr_rd_in) begin
			if (hit_cmd) begin
				st_nxt.rdata[HVB_BUSY_BIT]  = st_r.busy;
				st_nxt.rdata[HVB_RD_OK_BIT] = st_r.rd_ok;
				st_nxt.rdata[HVB_TX_OK_BIT] = st_r.tx_ok;
			end
			if (hit_dat)
				st_nxt.rdata[HVB_DAT_W-1:0] = {st_r.code, st_r.data};
		end

		if (sys_rst_in) begin
			st_nxt.busy       = 1'b0;
			st_nxt.tx_ok      = HVB_OK_RST;
			st_nxt.rd_ok      = HVB_OK_RST;
			st_nxt.code       = HVB_CODE_RST;
			st_nxt.data       = HVB_DATA_RST;
			st_nxt.pend_cmd   = HVB_RD_CFG_FIRST;
			st_nxt.req_tgl    = 1'b0;
			st_nxt.ack_seen   = st_r.ack_s;
			st_nxt.cfg_first  = HVB_CFG_RST;
			st_nxt.cfg_second = HVB_CFG_RST;
			st_nxt.rdata      = 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_in) begin
		st_r <= st_nxt;
	end

	// ----------------------------------------------------------------
	// Link side
	// ----------------------------------------------------------------
	assign xfer.req_tgl = st_r.req_tgl;
	assign xfer.cmd     = st_r.pend_cmd;
	assign xfer.wdata   = st_r.data;

	hvb_link_engine #(
		.DIV (SCLK_DIV)
	) u_link (
		.lnk_clk_in        (hv_clk_in),
		.sys_rst_in        (sys_rst_in),
		.xfer              (xfer),
		.hv_sclk_out       (hv_sclk_out),
		.hv_sdata_in       (hv_sdata_in),
		.hv_sdata_out      (hv_sdata_out),
		.hv_sdata_oe_n_out (hv_sdata_oe_n_out)
	);

	assign mmr_rdata_out        = st_r.rdata;
	assign busy_out             = st_r.busy;
	assign hv_config_first_out  = st_r.cfg_first;
	assign hv_config_second_out = st_r.cfg_second;

endmodule

// ===== inc/hvb_pkg.sv
// Shared constants of the high-voltage indirect register bridge.
package hvb_pkg;

	// ----------------------------------------------------------------
	// Register map and field layout
	// ----------------------------------------------------------------
	localparam logic [31:0] HVB_CMD_ADDR   = 32'hffff0804;
	localparam logic [31:0] HVB_DAT_ADDR   = 32'hffff080c;
	localparam int          HVB_CMD_W      = 8;
	localparam int          HVB_DAT_W      = 12;
	localparam int          HVB_BYTE_W     = 8;
	localparam int          HVB_CODE_W     = 4;
	localparam int          HVB_BUSY_BIT   = 0;
	localparam int          HVB_RD_OK_BIT  = 1;
	localparam int          HVB_TX_OK_BIT  = 2;
	localparam int          HVB_WR_CMD_BIT = 3;

	// ----------------------------------------------------------------
	// Command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] HVB_RD_CFG_FIRST  = 8'h00;
	localparam logic [7:0] HVB_RD_CFG_SECOND = 8'h01;
	localparam logic [7:0] HVB_RD_STATUS     = 8'h02;
	localparam logic [7:0] HVB_RD_MONITOR    = 8'h03;
	localparam logic [7:0] HVB_WR_CFG_FIRST  = 8'h08;
	localparam logic [7:0] HVB_WR_CFG_SECOND = 8'h09;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] HVB_CFG_RST  = 8'h00;
	localparam logic [7:0] HVB_DATA_RST = 8'h00;
	localparam logic [3:0] HVB_CODE_RST = 4'h0;
	localparam logic       HVB_OK_RST   = 1'b0;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam longint HVB_SYS_HZ     = 40_000_000;
	localparam longint HVB_LINK_HZ    = 20_480_000;
	localparam longint HVB_SCLK_HZ    = 2_560_000;
	localparam int     HVB_SCLK_DIV   = int'(HVB_LINK_HZ / HVB_SCLK_HZ);
	localparam longint HVB_MAX_LAT_NS = 10_000;
	localparam int     HVB_MAX_LAT_CYC =
		int'((HVB_MAX_LAT_NS * HVB_SYS_HZ) / 1_000_000_000);

	// ----------------------------------------------------------------
	// Serial frame: 8 command bits, 8 data bits, turnaround, ack
	// ----------------------------------------------------------------
	localparam int          HVB_FRAME_BITS = 18;
	localparam logic [4:0]  HVB_BIT_DATA0  = 5'h08;
	localparam logic [4:0]  HVB_BIT_TURN   = 5'h10;
	localparam logic [4:0]  HVB_BIT_ACK    = 5'h11;

endpackage

// ===== inc/hvb_xfer_if.sv
// Transfer request and result signals between the bus side and link side.
`timescale 1ns/1ps
interface hvb_xfer_if;
	logic       req_tgl;
	logic [7:0] cmd;
	logic [7:0] wdata;
	logic       ack_tgl;
	logic [7:0] rdata;
	logic       ok;

	modport ctl (output req_tgl, output cmd, output wdata,
		input ack_tgl, input rdata, input ok);
	modport lnk (input req_tgl, input cmd, input wdata,
		output ack_tgl, output rdata, output ok);
endinterface

// ===== rtl/hvb_link_engine.sv
// Serial link engine running on the high-voltage link clock.
`timescale 1ns/1ps
module hvb_link_engine #(
	parameter int DIV = hvb_pkg::HVB_SCLK_DIV
) (
	input  wire logic lnk_clk_in,     // Link clock
	input  wire logic sys_rst_in,     // Reset from the bus domain
	hvb_xfer_if.lnk   xfer,           // Request and result
	output logic      hv_sclk_out,    // Serial clock to the die
	input  wire logic hv_sdata_in,    // Serial data from the die
	output logic      hv_sdata_out,   // Serial data to the die
	output logic      hv_sdata_oe_n_out // Low while driving data
);
	import hvb_pkg::*;

	typedef enum {HVB_L_IDLE, HVB_L_SHIFT, HVB_L_DONE} hvb_lstate_e;

	typedef struct packed {
		logic        rst_m;
		logic        rst_s;
		logic        req_m;
		logic        req_s;
		logic        req_seen;
		logic        din_m;
		logic        din_s;
		hvb_lstate_e st;
		logic        is_rd;
		logic [15:0] sh;
		logic [4:0]  bitn;
		logic [7:0]  div;
		logic [7:0]  rd;
		logic        ok;
		logic        ack_tgl;
		logic        sclk;
		logic        dout;
		logic        oe_n;
	} hvb_link_s;

	hvb_link_s st_r;
	hvb_link_s st_nxt;

	// ----------------------------------------------------------------
	// Frame sequencer
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt       = st_r;
		st_nxt.rst_m = sys_rst_in;
		st_nxt.rst_s = st_r.rst_m;
		st_nxt.req_m = xfer.req_tgl;
		st_nxt.req_s = st_r.req_m;
		st_nxt.din_m = hv_sdata_in;
		st_nxt.din_s = st_r.din_m;
		case (st_r.st)
			HVB_L_IDLE: begin
				st_nxt.sclk = 1'b0;
				st_nxt.oe_n = 1'b1;
				if (st_r.req_s != st_r.req_seen) begin
					st_nxt.req_seen = st_r.req_s;
					st_nxt.sh       = {xfer.cmd, xfer.wdata};
					st_nxt.is_rd    = ~xfer.cmd[HVB_WR_CMD_BIT];
					st_nxt.bitn     = 5'h00;
					st_nxt.div      = 8'h00;
					st_nxt.st       = HVB_L_SHIFT;
				end
			end
			HVB_L_SHIFT: begin
				st_nxt.sclk = (st_r.div >= 8'(DIV / 2));
				st_nxt.div  = st_r.div + 8'h01;
				if (st_r.div == 8'h00) begin
					if (st_r.bitn < HVB_BIT_DATA0 ||
						(st_r.bitn < HVB_BIT_TURN && !st_r.is_rd)) begin
						st_nxt.dout = st_r.sh[15];
						st_nxt.oe_n = 1'b0;
						st_nxt.sh   = {st_r.sh[14:0], 1'b0};
					end else begin
						st_nxt.oe_n = 1'b1;
					end
				end
				if (st_r.div == 8'(DIV - 1)) begin
					st_nxt.div = 8'h00;
					if (st_r.is_rd && st_r.bitn >= HVB_BIT_DATA0 &&
						st_r.bitn < HVB_BIT_TURN)
						st_nxt.rd = {st_r.rd[6:0], st_r.din_s};
					if (st_r.bitn == HVB_BIT_ACK) begin
						st_nxt.ok = st_r.din_s;
						st_nxt.st = HVB_L_DONE;
					end
					st_nxt.bitn = st_r.bitn + 5'h01;
				end
			end
			HVB_L_DONE: begin
				st_nxt.sclk    = 1'b0;
				st_nxt.oe_n    = 1'b1;
				st_nxt.ack_tgl = ~st_r.ack_tgl;
				st_nxt.st      = HVB_L_IDLE;
			end
			default: st_nxt.st = HVB_L_IDLE;
		endcase
		if (st_r.rst_s) begin
			st_nxt.req_seen = st_r.req_s;
			st_nxt.st       = HVB_L_IDLE;
			st_nxt.is_rd    = 1'b0;
			st_nxt.sh       = 16'h0000;
			st_nxt.bitn     = 5'h00;
			st_nxt.div      = 8'h00;
			st_nxt.rd       = 8'h00;
			st_nxt.ok       = 1'b0;
			st_nxt.ack_tgl  = 1'b0;
			st_nxt.sclk     = 1'b0;
			st_nxt.dout     = 1'b0;
			st_nxt.oe_n     = 1'b1;
		end
	end

	always_ff @(posedge lnk_clk_in) begin
		st_r <= st_nxt;
	end

	assign xfer.ack_tgl      = st_r.ack_tgl;
	assign xfer.rdata        = st_r.rd;
	assign xfer.ok           = st_r.ok;
	assign hv_sclk_out       = st_r.sclk;
	assign hv_sdata_out      = st_r.dout;
	assign hv_sdata_oe_n_out = st_r.oe_n;

endmodule

// ===== verif/hvb_bridge_checker.sv
// Concurrent checks on the ports of the high-voltage bridge.
`timescale 1ns/1ps
module hvb_bridge_checker
	import hvb_pkg::*;
#(
	parameter int SCLK_DIV = 8
) (
	input wire logic        clk_in,
	input wire logic        sys_rst_in,
	input wire logic [31:0] mmr_addr_in,
	input wire logic        mmr_wr_in,
	input wire logic        mmr_rd_in,
	input wire logic [31:0] mmr_wdata_in,
	input wire logic [31:0] mmr_rdata_out,
	input wire logic        busy_out,
	input wire logic        hv_sclk_out,
	input wire logic        hv_sdata_oe_n_out
);
	localparam int LAT = 400;
	logic ok_code;
	assign ok_code = mmr_wdata_in[7:0] inside {[8'h00:8'h03], 8'h08, 8'h09};

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	sequence cmd_wr_s;
		mmr_wr_in && mmr_addr_in == HVB_CMD_ADDR && !busy_out;
	endsequence
	sequence go_s;
		cmd_wr_s ##0 ok_code;
	endsequence

	busy_start_a: assert property (go_s |=> busy_out)
		else $error("busy did not rise after a command");
	bad_code_a: assert property (cmd_wr_s ##0 !ok_code |=> !busy_out)
		else $error("undefined command started a transfer");
	busy_bound_a: assert property (go_s |-> ##[2:LAT] !busy_out)
		else $error("command not finished within latency");
	busy_hold_a: assert property ($rose(busy_out) |-> busy_out[*8])
		else $error("busy dropped too early");
	cmd_rb_a: assert property (mmr_rd_in && mmr_addr_in == HVB_CMD_ADDR |=>
		mmr_rdata_out[31:3] == 0 && mmr_rdata_out[0] == $past(busy_out))
		else $error("command readback wrong");
	dat_rb_a: assert property (mmr_rd_in && mmr_addr_in == HVB_DAT_ADDR |=>
		mmr_rdata_out[31:12] == 0)
		else $error("data readback too wide");
	map_a: assert property (mmr_rd_in && mmr_addr_in != HVB_CMD_ADDR &&
		mmr_addr_in != HVB_DAT_ADDR |=> mmr_rdata_out == 0)
		else $error("unmapped read returned data");
	link_idle_a: assert property (!busy_out |->
		!hv_sclk_out && hv_sdata_oe_n_out)
		else $error("link active without a command");
endmodule

bind hvb_bridge hvb_bridge_checker #(.SCLK_DIV(SCLK_DIV)) i_hvb_bridge_checker (
	.clk_in(clk_in), .sys_rst_in(sys_rst_in), .mmr_addr_in(mmr_addr_in),
	.mmr_wr_in(mmr_wr_in), .mmr_rd_in(mmr_rd_in),
	.mmr_wdata_in(mmr_wdata_in), .mmr_rdata_out(mmr_rdata_out),
	.busy_out(busy_out), .hv_sclk_out(hv_sclk_out),
	.hv_sdata_oe_n_out(hv_sdata_oe_n_out));

// ===== verif/hvb_die_model.sv
// Behavioural model of the register logic on the high-voltage die.
`timescale 1ns/1ps
module hvb_die_model #(
	parameter logic [7:0] STA = 8'h3c,
	parameter logic [7:0] MON = 8'ha5
) (
	input  wire logic       sys_rst_in, // Reset
	input  wire logic       sclk_in,    // Serial clock from bridge
	input  wire logic       line_in,    // Resolved data line
	input  wire logic       nack_in,    // Answer failure when high
	output logic            line_out,   // Die drive onto the line
	output logic [7:0]      cfg0_out,   // First config register
	output logic [7:0]      cfg1_out    // Second config register
);
	logic [4:0] cnt;
	logic [7:0] cmd;
	logic [7:0] dat;
	logic [7:0] rv;
	logic       en;
	logic       val;
	logic       last;
	always_comb begin
		case (cmd[1:0])
			2'h0: rv = cfg0_out;
			2'h1: rv = cfg1_out;
			2'h2: rv = STA;
			default: rv = MON;
		endcase
	end
	// A released line shows the opposite of its last level.
	assign line_out = en ? val : ~last;
	always @(posedge sclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cnt <= 5'h00;
			cfg0_out <= 8'h00;
			cfg1_out <= 8'h00;
		end else begin
			if (cnt < 8) cmd <= {cmd[6:0], line_in};
			else if (cnt < 16) dat <= {dat[6:0], line_in};
			if (cnt == 15 && !nack_in && cmd == 8'h08)
				cfg0_out <= {dat[6:0], line_in};
			if (cnt == 15 && !nack_in && cmd == 8'h09)
				cfg1_out <= {dat[6:0], line_in};
			cnt <= (cnt == 17) ? 5'h00 : cnt + 5'h01;
		end
	end
	always @(negedge sclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			en <= 1'b0;
			val <= 1'b0;
			last <= 1'b0;
		end else begin
			last <= line_in;
			en <= (cnt >= 8 && cnt < 16 && !cmd[3]) || cnt == 17;
			val <= (cnt == 17) ? !nack_in : rv[~cnt[2:0]];
		end
	end
endmodule

// ===== verif/tb.sv
// Self-checking bench of the high-voltage bridge against a die model.
`timescale 1ns/1ps
module tb;
	import hvb_pkg::*;
	logic        clk_in = 0, hv_clk = 0, sys_rst_in = 1;
	logic [31:0] addr, wdata, rdata, v;
	logic        wr, rd, busy, sclk, sd_o, oe_n, line, die_ln, nack;
	logic [7:0]  m0, m1, c0, c1;
	logic [7:0]  ev [4] = '{8'h5a, 8'hc3, 8'h3c, 8'ha5};
	logic [7:0]  bad [3] = '{8'h04, 8'h0a, 8'hff};
	int          bad_count = 0, num_checks = 0, cyc = 0;
	int          sclk_per = 0;
	realtime     t_rise = 0;

	always #12.5 clk_in = ~clk_in;
	always #24 hv_clk = ~hv_clk;
	assign line = oe_n ? die_ln : sd_o;

	// Spacing of serial clock rises, so the link rate can be checked.
	always @(posedge sclk) begin
		sclk_per = int'($realtime - t_rise);
		t_rise = $realtime;
	end

	hvb_bridge i_hvb_bridge (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.mmr_addr_in(addr), .mmr_wr_in(wr), .mmr_rd_in(rd),
		.mmr_wdata_in(wdata), .mmr_rdata_out(rdata), .busy_out(busy),
		.hv_config_first_out(m0), .hv_config_second_out(m1),
		.hv_clk_in(hv_clk), .hv_sclk_out(sclk), .hv_sdata_in(line),
		.hv_sdata_out(sd_o), .hv_sdata_oe_n_out(oe_n));
	hvb_die_model i_hvb_die_model (.sys_rst_in(sys_rst_in), .sclk_in(sclk),
		.line_in(line), .nack_in(nack), .line_out(die_ln),
		.cfg0_out(c0), .cfg1_out(c1));

	// ----------------------------------------------------------------
	// Bus access and comparison
	// ----------------------------------------------------------------
	task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_in);
		#1 addr = a;
		wdata = d;
		wr = 1;
		@(posedge clk_in);
		#1 wr = 0;
	endtask
	task automatic rd_reg(input logic [31:0] a, output logic [31:0] d);
		@(posedge clk_in);
		#1 addr = a;
		rd = 1;
		@(posedge clk_in);
		#1 rd = 0;
		d = rdata;
	endtask
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	// Issues a command, tries a write while busy, then polls until done.
	task automatic cmd(input logic [7:0] c, input logic [31:0] es);
		int i;
		wr_reg(HVB_CMD_ADDR, {24'h0, c});
		chk("busy_out", 1, busy);
		wr_reg(HVB_DAT_ADDR, 32'h0ff);
		for (i = 0; i < 200; i++) begin
			rd_reg(HVB_CMD_ADDR, v);
			if (v[0] === 1'b0) break;
		end
		chk("status", es, v);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			close_out();
		end
	end

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		{addr, wdata, wr, rd, nack} = '0;
		repeat (20) @(posedge clk_in);
		#1 sys_rst_in = 0;
		rd_reg(HVB_CMD_ADDR, v);
		chk("cmd reset", 0, v);
		rd_reg(HVB_DAT_ADDR, v);
		chk("dat reset", 0, v);
		chk("mirror first", 0, m0);
		wr_reg(HVB_DAT_ADDR, 32'h05a);
		cmd(HVB_WR_CFG_FIRST, 32'h4);
		chk("die first", 8'h5a, c0);
		chk("mirror first", 8'h5a, m0);
		chk("sclk period", 32'(HVB_SCLK_DIV * 48), sclk_per);
		wr_reg(HVB_DAT_ADDR, 32'h0c3);
		cmd(HVB_WR_CFG_SECOND, 32'h4);
		chk("die second", 8'hc3, c1);
		chk("mirror second", 8'hc3, m1);
		rd_reg(HVB_DAT_ADDR, v);
		chk("dat write", 32'h9c3, v);
		for (int i = 0; i < 4; i++) begin
			cmd(8'(i), 32'h6);
			rd_reg(HVB_DAT_ADDR, v);
			chk("dat read", {20'h0, 4'(i), ev[i]}, v);
		end
		for (int i = 0; i < 3; i++) begin
			wr_reg(HVB_CMD_ADDR, {24'h0, bad[i]});
			chk("busy_out idle", 0, busy);
			rd_reg(HVB_DAT_ADDR, v);
			chk("dat kept", 32'h3a5, v);
		end
		rd_reg(32'hffff0808, v);
		chk("unmapped", 0, v);
		nack = 1;
		cmd(HVB_RD_CFG_SECOND, 32'h4);
		rd_reg(HVB_DAT_ADDR, v);
		chk("dat failed", 32'h1a5, v);
		wr_reg(HVB_DAT_ADDR, 32'h011);
		cmd(HVB_WR_CFG_FIRST, 32'h0);
		chk("mirror kept", 8'h5a, m0);
		chk("die kept", 8'h5a, c0);
		nack = 0;
		// A second reset in mid-run must clear the registers once more.
		sys_rst_in = 1;
		repeat (20) @(posedge clk_in);
		#1 sys_rst_in = 0;
		rd_reg(HVB_DAT_ADDR, v);
		chk("dat rerun", 0, v);
		chk("mirror rerun", 0, m1);
		cmd(HVB_RD_CFG_SECOND, 32'h6);
		rd_reg(HVB_DAT_ADDR, v);
		chk("die rerun", 32'h100, v);
		close_out();
	end
endmodule
